// ===== logic/tbop_defs.svh
/*
 * Offsets, field positions, reset values and counts for the trace buffer
 * and off-chip trace port. Assumes inclusion by bare name, once per unit.
 */
`ifndef TBOP_DEFS_SVH
`define TBOP_DEFS_SVH

// register offsets on the debug-segment register port
`define TBOP_OFS_WORD_LO 14'h3f80
`define TBOP_OFS_WORD_HI 14'h3f84
`define TBOP_OFS_RDP 14'h3f88
`define TBOP_OFS_WRP 14'h3f90
`define TBOP_OFS_ITRIG 14'h3fd0
`define TBOP_OFS_DTRIG 14'h3fd8

// buffer geometry: 256 words of 64 bits, byte address bits 10:0
`define TBOP_IDX_W 8
`define TBOP_ADDR_MSB 10
`define TBOP_WORD_LSB 3

// field positions
`define TBOP_WRAP_BIT 31
`define TBOP_GATE_BIT 28
`define TBOP_ACT_W 15

// reset values
`define TBOP_TRIG_RST 15'h0000
`define TBOP_IDX_RST 8'h00

// start tag encoding
`define TBOP_TAG_W 6
`define TBOP_TAG_POS0 6'h3a
`define TBOP_TAG_POS16 6'h3b
`define TBOP_TAG_POS32 6'h3c
`define TBOP_TAG_POS48 6'h3d

// nibbles per 64-bit word
`define TBOP_NIBBLES 5'h10
`define TBOP_LAST_NIB 4'hf

`endif

// ===== logic/tbop_pkg.sv
/*
 * Types shared by the trace buffer and off-chip port.
 * Assumes tbop_defs.svh is on the include path.
 */
`include "tbop_defs.svh"

package tbop_pkg;

    typedef enum logic {DRAIN_IDLE, DRAIN_SHIFT} tbop_drain_e;

    // one trace message chunk offered by the trace generator
    typedef struct packed {
        logic valid;
        logic [`TBOP_TAG_W-1:0] start_pos;
        logic [63-`TBOP_TAG_W:0] body;
    } tbop_trace_in_s;

    // register port request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [13:0] addr;
        logic [31:0] wdata;
    } tbop_reg_req_s;

    // register port answer
    typedef struct packed {
        logic rvalid;
        logic [31:0] rdata;
    } tbop_reg_rsp_s;

    // off-chip pins
    typedef struct packed {
        logic clk;
        logic [3:0] nibble;
    } tbop_port_s;

    typedef struct packed {
        logic [`TBOP_IDX_W-1:0] rd_idx;
        logic [`TBOP_IDX_W-1:0] wr_idx;
        logic wrap;
        logic itrig_gate;
        logic [`TBOP_ACT_W-1:0] itrig_act;
        logic dtrig_gate;
        logic [`TBOP_ACT_W-1:0] dtrig_act;
        logic trace_on;
        logic event_pulse;
        tbop_reg_rsp_s rsp;
        tbop_drain_e drain_state;
        logic [`TBOP_IDX_W-1:0] drain_idx;
        logic [63:0] shift;
        logic [3:0] nib_cnt;
        logic phase;
        tbop_port_s port;
    } tbop_state_s;

endpackage

// ===== logic/tbop_top.sv
/*
 * On-chip circular trace buffer with software read-out registers and a
 * nibble-wide off-chip probe port on a divided double-edge trace clock.
 * Assumes: one core clock, register port accesses are single-cycle strobes
 * with read and write never in the same cycle, trigger inputs are pulses.
 */
`timescale 1ns/1ps
`include "tbop_defs.svh"

module tbop_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register port
    input wire tbop_pkg::tbop_reg_req_s reg_req,
    output tbop_pkg::tbop_reg_rsp_s reg_rsp,
    // trace generator
    input wire tbop_pkg::tbop_trace_in_s trace_in,
    input wire logic special_mode,
    input wire logic sw_trace_load,
    input wire logic sw_trace_value,
    // breakpoint triggers
    input wire logic [`TBOP_ACT_W-1:0] instr_break_trig,
    input wire logic [`TBOP_ACT_W-1:0] data_break_trig,
    // off-chip control
    input wire logic offchip_enable,
    input wire logic port_speed_select,
    input wire logic probe_absent_n,
    // status
    output logic trace_on,
    output logic trace_event,
    // off-chip pins
    output logic trace_port_clock,
    output logic [3:0] trace_nibble_out
);
    import tbop_pkg::*;

    localparam int DEPTH = 1 << `TBOP_IDX_W;

    tbop_state_s s_q;
    tbop_state_s s_d;
    logic [63:0] buf_mem [DEPTH];
    logic store;
    logic [63:0] store_word;

    function automatic logic [`TBOP_IDX_W-1:0] next_idx(input logic [`TBOP_IDX_W-1:0] i);
        next_idx = i + `TBOP_IDX_W'(1);
    endfunction

    // pointer index to register image with the word offset bits zero
    function automatic logic [31:0] ptr_image(input logic [`TBOP_IDX_W-1:0] i);
        ptr_image = {{(31 - `TBOP_ADDR_MSB){1'b0}}, i, 3'h0};
    endfunction

    function automatic logic [`TBOP_TAG_W-1:0] start_tag_code(
        input logic [`TBOP_TAG_W-1:0] pos
    );
        case (pos)
            6'h00: start_tag_code = `TBOP_TAG_POS0;
            6'h10: start_tag_code = `TBOP_TAG_POS16;
            6'h20: start_tag_code = `TBOP_TAG_POS32;
            6'h30: start_tag_code = `TBOP_TAG_POS48;
            default: start_tag_code = pos;
        endcase
    endfunction

    // reset image: pointers start at the buffer bottom, trigger actions all stop
    function automatic tbop_state_s reset_state();
        reset_state = '0;
        reset_state.rd_idx = `TBOP_IDX_RST;
        reset_state.wr_idx = `TBOP_IDX_RST;
        reset_state.drain_idx = `TBOP_IDX_RST;
        reset_state.itrig_act = `TBOP_TRIG_RST;
        reset_state.dtrig_act = `TBOP_TRIG_RST;
    endfunction

    localparam tbop_state_s STATE_RST = reset_state();

    // the tag fills the low six bits, so the first nibble out is never zero
    assign store_word = {trace_in.body, start_tag_code(trace_in.start_pos)};
    // words offered while tracing is off are dropped, not queued
    assign store = s_q.trace_on & trace_in.valid;

    always_ff @(posedge sys_clk)
    begin
        if (store)
        begin
            buf_mem[s_q.wr_idx] <= store_word;
        end
    end

    always_comb
    begin
        logic [`TBOP_ACT_W-1:0] ihit;
        logic [`TBOP_ACT_W-1:0] dhit;
        logic any_hit;
        logic start_hit;
        logic stop_hit;
        logic port_live;
        logic tick;
        logic [63:0] rd_word;
        logic [63:0] drain_word;
        ihit = '0;
        dhit = '0;
        any_hit = 1'b0;
        start_hit = 1'b0;
        stop_hit = 1'b0;
        port_live = 1'b0;
        tick = 1'b0;
        rd_word = buf_mem[s_q.rd_idx];
        drain_word = buf_mem[s_q.drain_idx];
        s_d = s_q;
        s_d.rsp.rvalid = 1'b0;
        s_d.event_pulse = 1'b0;

        // breakpoint triggers
        ihit = instr_break_trig & {`TBOP_ACT_W{s_q.itrig_gate}};
        dhit = data_break_trig & {`TBOP_ACT_W{s_q.dtrig_gate}};
        any_hit = |{ihit, dhit};
        start_hit = |{ihit & s_q.itrig_act, dhit & s_q.dtrig_act};
        stop_hit = |{ihit & ~s_q.itrig_act, dhit & ~s_q.dtrig_act};
        if (special_mode)
        begin
            s_d.event_pulse = any_hit;
        end
        else if (start_hit)
        begin
            // a start and a stop together leave tracing on
            s_d.trace_on = 1'b1;
        end
        else if (stop_hit)
        begin
            s_d.trace_on = 1'b0;
        end
        // a software load overrides any trigger in the same cycle
        if (sw_trace_load)
        begin
            s_d.trace_on = sw_trace_value;
        end

        // register port
        // a write that meets a read in the same cycle is dropped
        if (reg_req.rd)
        begin
            s_d.rsp.rvalid = 1'b1;
            case (reg_req.addr)
                `TBOP_OFS_WORD_LO:
                begin
                    s_d.rsp.rdata = rd_word[31:0];
                    s_d.rd_idx = next_idx(s_q.rd_idx);
                end
                `TBOP_OFS_WORD_HI: s_d.rsp.rdata = rd_word[63:32];
                `TBOP_OFS_RDP: s_d.rsp.rdata = ptr_image(s_q.rd_idx);
                `TBOP_OFS_WRP:
                begin
                    s_d.rsp.rdata = ptr_image(s_q.wr_idx);
                    s_d.rsp.rdata[`TBOP_WRAP_BIT] = s_q.wrap;
                end
                `TBOP_OFS_ITRIG:
                begin
                    s_d.rsp.rdata = {17'h00000, s_q.itrig_act};
                    s_d.rsp.rdata[`TBOP_GATE_BIT] = s_q.itrig_gate;
                end
                `TBOP_OFS_DTRIG:
                begin
                    s_d.rsp.rdata = {17'h00000, s_q.dtrig_act};
                    s_d.rsp.rdata[`TBOP_GATE_BIT] = s_q.dtrig_gate;
                end
                default: s_d.rsp.rdata = 32'h0000_0000;
            endcase
        end
        else if (reg_req.wr)
        begin
            case (reg_req.addr)
                `TBOP_OFS_RDP:
                    // reserved bits and the three word-offset bits are not stored
                    s_d.rd_idx = reg_req.wdata[`TBOP_ADDR_MSB:`TBOP_WORD_LSB];
                `TBOP_OFS_WRP:
                begin
                    s_d.wr_idx = reg_req.wdata[`TBOP_ADDR_MSB:`TBOP_WORD_LSB];
                    s_d.wrap = reg_req.wdata[`TBOP_WRAP_BIT];
                end
                `TBOP_OFS_ITRIG:
                begin
                    s_d.itrig_gate = reg_req.wdata[`TBOP_GATE_BIT];
                    s_d.itrig_act = reg_req.wdata[`TBOP_ACT_W-1:0];
                end
                `TBOP_OFS_DTRIG:
                begin
                    s_d.dtrig_gate = reg_req.wdata[`TBOP_GATE_BIT];
                    s_d.dtrig_act = reg_req.wdata[`TBOP_ACT_W-1:0];
                end
                default: ;
            endcase
        end

        // storing: a software write of the write pointer in the same cycle
        // keeps its address, but a rollover still sets the wrap flag
        if (store)
        begin
            if (!(reg_req.wr && reg_req.addr == `TBOP_OFS_WRP))
            begin
                s_d.wr_idx = next_idx(s_q.wr_idx);
            end
            if (s_q.wr_idx == {`TBOP_IDX_W{1'b1}})
            begin
                s_d.wrap = 1'b1;
            end
        end

        // off-chip probe interface
        port_live = offchip_enable & ~probe_absent_n;
        tick = port_speed_select | s_q.phase;
        if (!port_live)
        begin
            // nothing pending while disabled; the drain picks up new words only
            s_d.drain_idx = s_d.wr_idx;
            s_d.drain_state = DRAIN_IDLE;
            s_d.phase = 1'b0;
            s_d.port.clk = 1'b0;
            s_d.port.nibble = 4'h0;
            s_d.nib_cnt = 4'h0;
        end
        else
        begin
            // phase runs while live, so half speed ticks on every second cycle
            s_d.phase = ~s_q.phase;
            if (tick)
            begin
                s_d.port.clk = ~s_q.port.clk;
                case (s_q.drain_state)
                    DRAIN_IDLE:
                    begin
                        // an overrun by the writer is not detected here
                        if (s_q.drain_idx != s_q.wr_idx)
                        begin
                            s_d.port.nibble = drain_word[3:0];
                            s_d.shift = drain_word >> 4;
                            s_d.drain_idx = next_idx(s_q.drain_idx);
                            s_d.nib_cnt = 4'h1;
                            s_d.drain_state = DRAIN_SHIFT;
                        end
                        else
                        begin
                            s_d.port.nibble = 4'h0;
                        end
                    end
                    DRAIN_SHIFT:
                    begin
                        s_d.port.nibble = s_q.shift[3:0];
                        s_d.shift = s_q.shift >> 4;
                        s_d.nib_cnt = s_q.nib_cnt + 4'h1;
                        if (s_q.nib_cnt == `TBOP_LAST_NIB)
                        begin
                            s_d.drain_state = DRAIN_IDLE;
                        end
                    end
                    default: s_d.drain_state = DRAIN_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= STATE_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign reg_rsp = s_q.rsp;
    assign trace_on = s_q.trace_on;
    assign trace_event = s_q.event_pulse;
    assign trace_port_clock = s_q.port.clk;
    assign trace_nibble_out = s_q.port.nibble;

endmodule // tbop_top

// ===== test/tbop_probe.sv
/*
 * Behavioural trace probe on the off-chip pins; assembles 64-bit words.
 * Assumes it is the only load on the pins; samples 1 ns after each clock edge.
 */
`timescale 1ns/1ps
module tbop_probe (
    // trace pins
    input wire logic trace_port_clock,
    input wire logic [3:0] trace_nibble_out,
    // probe side
    input wire logic attached,
    output logic probe_absent_n,
    output logic [63:0] word,
    output logic [7:0] word_cnt
);
    logic [63:0] acc;
    logic [4:0] idx;
    // pulled high when the cable is off
    assign probe_absent_n = !attached;
    initial
    begin
        idx = 5'h0;
        word = 64'h0;
        word_cnt = 8'h0;
    end
    // both edges carry data; sample 1 ns after the edge so the launch edge has settled
    always @(trace_port_clock)
    begin
        #1;
        if (idx != 5'h0 || trace_nibble_out != 4'h0)
        begin
            acc = {trace_nibble_out, acc[63:4]};
            idx = idx + 5'h1;
        end
        if (idx == 5'h10)
        begin
            word = acc;
            word_cnt = word_cnt + 8'h1;
            idx = 5'h0;
        end
    end
endmodule // tbop_probe

// ===== test/tbop_chk.sv
/*
 * Port assertions for the trace buffer and off-chip port.
 * Assumes it is bound to tbop_top and sees only its ports.
 */
`timescale 1ns/1ps
`include "tbop_defs.svh"
module tbop_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register port
    input wire tbop_pkg::tbop_reg_req_s reg_req,
    input wire tbop_pkg::tbop_reg_rsp_s reg_rsp,
    // control and pins
    input wire logic special_mode,
    input wire logic offchip_enable,
    input wire logic port_speed_select,
    input wire logic probe_absent_n,
    input wire logic trace_event,
    input wire logic trace_port_clock,
    input wire logic [3:0] trace_nibble_out
);
    import tbop_pkg::*;
    logic act;
    logic [13:0] a;
    assign act = offchip_enable && !probe_absent_n;
    assign a = reg_req.addr;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_rd_answer;
        reg_req.rd |=> reg_rsp.rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rdp_image;
        reg_req.rd && a == `TBOP_OFS_RDP |=> reg_rsp.rdata[31:11] == 21'h0 && reg_rsp.rdata[2:0] == 3'h0;
    endproperty
    a_rdp_image: assert property (p_rdp_image) else $error("read pointer image");
    property p_wrp_image;
        reg_req.rd && a == `TBOP_OFS_WRP |=> reg_rsp.rdata[30:11] == 20'h0 && reg_rsp.rdata[2:0] == 3'h0;
    endproperty
    a_wrp_image: assert property (p_wrp_image) else $error("write pointer image");
    property p_trig_image;
        reg_req.rd && a inside {`TBOP_OFS_ITRIG, `TBOP_OFS_DTRIG}
            |=> reg_rsp.rdata[31:29] == 3'h0 && reg_rsp.rdata[27:15] == 13'h0;
    endproperty
    a_trig_image: assert property (p_trig_image) else $error("trigger reg image");
    property p_unmapped;
        reg_req.rd && a == 14'h3f00 |=> reg_rsp.rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_idle;
        !act |=> !trace_port_clock && trace_nibble_out == 4'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("port not quiet");
    property p_full_speed;
        (act && port_speed_select)[*2] |=> trace_port_clock != $past(trace_port_clock);
    endproperty
    a_full_speed: assert property (p_full_speed) else $error("full speed clock");
    property p_half_speed;
        (act && !port_speed_select)[*3] |=> trace_port_clock != $past(trace_port_clock, 2);
    endproperty
    a_half_speed: assert property (p_half_speed) else $error("half speed clock");
    property p_nib_edges;
        act |=> $stable(trace_port_clock) -> $stable(trace_nibble_out);
    endproperty
    a_nib_edges: assert property (p_nib_edges) else $error("nibble off clock edge");
    property p_no_event;
        !special_mode |=> !trace_event;
    endproperty
    a_no_event: assert property (p_no_event) else $error("event in normal mode");
endmodule // tbop_chk
bind tbop_top tbop_chk u_chk (.sys_clk, .reset_n, .reg_req, .reg_rsp, .special_mode,
    .offchip_enable, .port_speed_select, .probe_absent_n, .trace_event, .trace_port_clock,
    .trace_nibble_out);

// ===== test/tbop_top_bench.sv
/*
 * Register-level testbench for the trace buffer and off-chip port.
 * Assumes tbop_top, its checker and the probe model are compiled before it.
 */
`timescale 1ns/1ps
`include "tbop_defs.svh"
module tbop_top_bench;
    import tbop_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n, special_mode, sw_trace_load, offchip_enable, port_speed_select;
    logic attached, probe_absent_n, trace_on, trace_event, trace_port_clock;
    logic [3:0] trace_nibble_out;
    logic [14:0] ibt, dbt;
    logic [63:0] pw, ev;
    logic sw_trace_value;
    logic [7:0] pcnt;
    logic [5:0] pos [7] = '{6'h00, 6'h10, 6'h20, 6'h30, 6'h05, 6'h00, 6'h21};
    tbop_reg_req_s reg_req;
    tbop_reg_rsp_s reg_rsp;
    tbop_trace_in_s trace_in;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    always #2 sys_clk = ~sys_clk;
    tbop_top u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rsp(reg_rsp),
        .trace_in(trace_in), .special_mode(special_mode), .sw_trace_load(sw_trace_load),
        .sw_trace_value(sw_trace_value), .instr_break_trig(ibt), .data_break_trig(dbt),
        .offchip_enable(offchip_enable), .port_speed_select(port_speed_select),
        .probe_absent_n(probe_absent_n), .trace_on(trace_on), .trace_event(trace_event),
        .trace_port_clock(trace_port_clock), .trace_nibble_out(trace_nibble_out));
    tbop_probe u_probe (.trace_port_clock(trace_port_clock), .trace_nibble_out(trace_nibble_out),
        .attached(attached), .probe_absent_n(probe_absent_n), .word(pw), .word_cnt(pcnt));
    task finish_test;
        if (errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            finish_test;
        end
    end
    task chk(input logic [63:0] g, input logic [63:0] e);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [13:0] a, input logic [31:0] d);
        @(posedge sys_clk) #1 reg_req = '{1'b0, 1'b1, a, d};
        @(posedge sys_clk) #1 reg_req.wr = 1'b0;
    endtask
    // answer is registered on the taking edge and checked 1 ns after it
    task rdc(input logic [13:0] a, input logic [31:0] e);
        @(posedge sys_clk) #1 reg_req = '{1'b1, 1'b0, a, 32'h0};
        @(posedge sys_clk) #1 reg_req.rd = 1'b0;
        chk({reg_rsp.rvalid, reg_rsp.rdata}, {1'b1, e});
    endtask
    task trig(input logic [14:0] i, input logic [14:0] d);
        @(posedge sys_clk) #1 ibt = i;
        dbt = d;
        @(posedge sys_clk) #1 ibt = 15'h0;
        dbt = 15'h0;
    endtask
    function automatic logic [63:0] ew(input int i);
        logic [5:0] t;
        case (pos[i])
            6'h00: t = 6'h3a;
            6'h10: t = 6'h3b;
            6'h20: t = 6'h3c;
            6'h30: t = 6'h3d;
            default: t = pos[i];
        endcase
        return {58'h155_aaaa_0f0f_1230 + 58'(i), t};
    endfunction
    task put(input int i);
        @(posedge sys_clk) #1 trace_in = '{1'b1, pos[i], 58'h155_aaaa_0f0f_1230 + 58'(i)};
        @(posedge sys_clk) #1 trace_in.valid = 1'b0;
    endtask
    initial
    begin
        reset_n = 1'b0;
        {special_mode, sw_trace_load, sw_trace_value, offchip_enable, ibt, dbt} = '0;
        {port_speed_select, attached} = 2'b11;
        reg_req = '0;
        trace_in = '0;
        repeat (6) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        rdc(`TBOP_OFS_ITRIG, 32'h0);
        wr(`TBOP_OFS_DTRIG, 32'hffff_ffff);
        rdc(`TBOP_OFS_DTRIG, 32'h1000_7fff);
        rdc(14'h3f00, 32'h0);
        wr(`TBOP_OFS_ITRIG, 32'h0000_0001);
        trig(15'h1, 15'h0);
        chk(trace_on, 1'b0);
        wr(`TBOP_OFS_ITRIG, 32'h1000_0001);
        special_mode = 1'b1;
        trig(15'h1, 15'h0);
        chk({trace_on, trace_event}, 2'b01);
        special_mode = 1'b0;
        trig(15'h1, 15'h0);
        chk(trace_on, 1'b1);
        wr(`TBOP_OFS_DTRIG, 32'h1000_0000);
        trig(15'h0, 15'h8);
        chk(trace_on, 1'b0);
        trig(15'h1, 15'h0);
        wr(`TBOP_OFS_WRP, 32'h0);
        wr(`TBOP_OFS_RDP, 32'h0);
        offchip_enable = 1'b1;
        for (int i = 0; i < 5; i++)
            put(i);
        rdc(`TBOP_OFS_WRP, 32'h28);
        for (int i = 0; i < 5; i++)
        begin
            ev = ew(i);
            rdc(`TBOP_OFS_WORD_HI, ev[63:32]);
            rdc(`TBOP_OFS_RDP, 32'(i * 8));
            rdc(`TBOP_OFS_WORD_LO, ev[31:0]);
        end
        rdc(`TBOP_OFS_RDP, 32'h28);
        repeat (100) @(posedge sys_clk);
        chk(pcnt, 8'h5);
        chk(pw, ew(4));
        #1 offchip_enable = 1'b0;
        wr(`TBOP_OFS_WRP, 32'h7f8);
        put(5);
        rdc(`TBOP_OFS_WRP, 32'h8000_0000);
        wr(`TBOP_OFS_RDP, 32'hffff_ffff);
        rdc(`TBOP_OFS_RDP, 32'h7f8);
        ev = ew(5);
        rdc(`TBOP_OFS_WORD_HI, ev[63:32]);
        rdc(`TBOP_OFS_WORD_LO, ev[31:0]);
        rdc(`TBOP_OFS_RDP, 32'h0);
        port_speed_select = 1'b0;
        offchip_enable = 1'b1;
        put(6);
        repeat (150) @(posedge sys_clk);
        chk({pcnt, pw}, {8'h6, ew(6)});
        #1 sw_trace_load = 1'b1;
        @(posedge sys_clk) #1 sw_trace_load = 1'b0;
        chk(trace_on, 1'b0);
        put(0);
        rdc(`TBOP_OFS_WRP, 32'h8000_0008);
        attached = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1 chk({trace_port_clock, trace_nibble_out}, 5'h0);
        finish_test;
    end
endmodule // tbop_top_bench
